/* hw/cms_defines.svh */
// timing and width constants for the configuration mode sequencer
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
`define CMS_CLK_MHZ          200
`define CMS_POR_LONG_MS      100
`define CMS_POR_SHORT_MS     12
`define CMS_POR_LONG_CYC     (`CMS_POR_LONG_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_POR_SHORT_CYC    (`CMS_POR_SHORT_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_CNT_W            25
`define CMS_INIT_CYC         16
`define CMS_DATA_W           8
`endif

/* hw/cms_pkg.sv */
// types for the configuration mode sequencer
`default_nettype none
package cms_pkg;
  typedef enum logic [2:0] {
    CMS_POR,
    CMS_WAIT_REQ,
    CMS_LOAD,
    CMS_INIT,
    CMS_USER
  } cms_state_t;
  typedef enum logic [1:0] {
    CMS_LOAD_FAST_PARALLEL,
    CMS_LOAD_ACTIVE_SERIAL,
    CMS_LOAD_PASSIVE_SERIAL,
    CMS_LOAD_PARALLEL_ASYNC
  } cms_scheme_t;
endpackage
`default_nettype wire

/* hw/cms_sequencer.sv */
// power-up, configuration, initialization and user mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.svh"
// Behaviour
// - After every reset the device loads a full configuration before it can enter user mode; the code ends loading once cfg_last is high, even with no data.
// - After configuration an initialization phase clears user registers; I/O is enabled in the same cycle that user logic starts.
// - User I/O stays high impedance during power-up, before and throughout configuration.
// - Configuration and initialization form command mode; user mode follows only after it.
// - A reconfiguration request forces the device back into command mode to reload and reinitialize.
// - The power-on delay is 100 ms with the delay select low and 12 ms with it high.
// - Before and during configuration weak pull-ups are off when the disable input is high, on when low.
// - Compressed data is expanded on the fly as it arrives, without storing the whole image.
// - Data may arrive serially or in parallel, synchronously or by an asynchronous write strobe.
module cms_sequencer #(
  parameter int unsigned POR_LONG_CYC  = `CMS_POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYC = `CMS_POR_SHORT_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   power_on_delay_select,
  input  wire logic                   preconfig_pullup_disable,
  input  wire logic                   reconfig_request_n,
  input  wire logic [1:0]             load_scheme,
  input  wire logic                   compressed,
  input  wire logic                   cfg_clk,
  input  wire logic                   cfg_wr_n,
  input  wire logic [`CMS_DATA_W-1:0] cfg_data,
  input  wire logic                   cfg_last,
  output logic                        command_mode,
  output logic                        user_mode,
  output logic                        io_oe_n,
  output logic                        weak_pullup_en,
  output logic                        user_reg_clear,
  output logic                        cfg_byte_valid,
  output logic [`CMS_DATA_W-1:0]      cfg_byte,
  output logic                        config_done
);
  // two-stage synchronisers for pins
  logic [1:0] rq_s_q, dsel_s_q, pud_s_q, clk_s_q, wr_s_q, last_s_q;
  logic [1:0] rq_s_d, dsel_s_d, pud_s_d, clk_s_d, wr_s_d, last_s_d;
  logic [`CMS_DATA_W-1:0] data_s0_q, data_s1_q, data_s0_d, data_s1_d;
  logic clk_prev_q, clk_prev_d, wr_prev_q, wr_prev_d, rq_prev_q, rq_prev_d;

  always_comb begin
    rq_s_d     = {rq_s_q[0], reconfig_request_n};
    dsel_s_d   = {dsel_s_q[0], power_on_delay_select};
    pud_s_d    = {pud_s_q[0], preconfig_pullup_disable};
    clk_s_d    = {clk_s_q[0], cfg_clk};
    wr_s_d     = {wr_s_q[0], cfg_wr_n};
    last_s_d   = {last_s_q[0], cfg_last};
    data_s0_d  = cfg_data;
    data_s1_d  = data_s0_q;
    clk_prev_d = clk_s_q[1];
    wr_prev_d  = wr_s_q[1];
    rq_prev_d  = rq_s_q[1];
  end

  // no reset: pins settle while reset is held, so the first power-on
  // count sees the real select and pull-up levels, and no false edge follows
  always_ff @(posedge clock) begin
    rq_s_q     <= rq_s_d;
    dsel_s_q   <= dsel_s_d;
    pud_s_q    <= pud_s_d;
    clk_s_q    <= clk_s_d;
    wr_s_q     <= wr_s_d;
    last_s_q   <= last_s_d;
    data_s0_q  <= data_s0_d;
    data_s1_q  <= data_s1_d;
    clk_prev_q <= clk_prev_d;
    wr_prev_q  <= wr_prev_d;
    rq_prev_q  <= rq_prev_d;
  end

  // falling edge of the reconfiguration request
  wire logic rq_fall = rq_prev_q & ~rq_s_q[1];
  wire logic rq_low  = ~rq_s_q[1];

  // one sample strobe per scheme
  function automatic logic scheme_strobe(input logic [1:0] sch, input logic ck_rise,
                                         input logic wr_rise);
    if (sch == cms_pkg::CMS_LOAD_PARALLEL_ASYNC) begin
      scheme_strobe = wr_rise;
    end else begin
      scheme_strobe = ck_rise;
    end
  endfunction

  cms_pkg::cms_state_t state_q, state_d;
  logic [`CMS_CNT_W-1:0] cnt_q, cnt_d;
  logic dsel_q, dsel_d, pud_q, pud_d;
  logic [1:0] sch_q, sch_d;
  logic cmp_q, cmp_d;
  logic [2:0] bit_q, bit_d;
  logic [`CMS_DATA_W-1:0] sh_q, sh_d, byte_q, byte_d;
  logic bv_q, bv_d, done_q, done_d;
  // run-length expander: a zero byte with a count byte repeats the previous byte
  logic rle_esc_q, rle_esc_d;
  logic [`CMS_DATA_W-1:0] rle_rep_q, rle_rep_d, prev_q, prev_d;

  logic strobe, serial;
  logic [`CMS_DATA_W-1:0] word;
  logic word_ok;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    dsel_d    = dsel_q;
    pud_d     = pud_q;
    sch_d     = sch_q;
    cmp_d     = cmp_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    byte_d    = byte_q;
    bv_d      = 1'b0;
    done_d    = done_q;
    rle_esc_d = rle_esc_q;
    rle_rep_d = rle_rep_q;
    prev_d    = prev_q;
    word      = data_s1_q;
    word_ok   = 1'b0;
    serial    = (sch_q == cms_pkg::CMS_LOAD_ACTIVE_SERIAL) ||
                (sch_q == cms_pkg::CMS_LOAD_PASSIVE_SERIAL);
    strobe    = scheme_strobe(sch_q, clk_s_q[1] & ~clk_prev_q, wr_s_q[1] & ~wr_prev_q);
    case (state_q)
      cms_pkg::CMS_POR: begin
        if (cnt_q == '0) begin
          dsel_d = dsel_s_q[1];
          pud_d  = pud_s_q[1];
        end
        cnt_d = cnt_q + 1'b1;
        if ((dsel_q && cnt_q >= POR_SHORT_CYC[`CMS_CNT_W-1:0] - 1'b1) ||
            (!dsel_q && cnt_q >= POR_LONG_CYC[`CMS_CNT_W-1:0] - 1'b1)) begin
          state_d = cms_pkg::CMS_WAIT_REQ;
          cnt_d   = '0;
        end
      end
      cms_pkg::CMS_WAIT_REQ: begin
        if (!rq_low) begin
          state_d   = cms_pkg::CMS_LOAD;
          pud_d     = pud_s_q[1];
          sch_d     = load_scheme;
          cmp_d     = compressed;
          bit_d     = '0;
          rle_esc_d = 1'b0;
          done_d    = 1'b0;
        end
      end
      cms_pkg::CMS_LOAD: begin
        if (strobe) begin
          if (serial) begin
            sh_d  = {data_s1_q[0], sh_q[`CMS_DATA_W-1:1]};
            bit_d = bit_q + 1'b1;
            word  = {data_s1_q[0], sh_q[`CMS_DATA_W-1:1]};
            word_ok = (bit_q == 3'h7);
          end else begin
            word_ok = 1'b1;
          end
        end
        if (word_ok) begin
          if (!cmp_q) begin
            byte_d = word;
            bv_d   = 1'b1;
          end else if (rle_esc_q) begin
            rle_esc_d = 1'b0;
            rle_rep_d = word;
          end else if (word == 8'h00) begin
            rle_esc_d = 1'b1;
          end else begin
            byte_d = word;
            prev_d = word;
            bv_d   = 1'b1;
          end
        end else if (rle_rep_q != '0) begin
          byte_d    = prev_q;
          bv_d      = 1'b1;
          rle_rep_d = rle_rep_q - 1'b1;
        end
        if (last_s_q[1] && !word_ok && rle_rep_q == '0 && !rle_esc_q) begin
          state_d = cms_pkg::CMS_INIT;
          cnt_d   = '0;
        end
      end
      cms_pkg::CMS_INIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == `CMS_INIT_CYC - 1) begin
          state_d = cms_pkg::CMS_USER;
          done_d  = 1'b1;
        end
      end
      cms_pkg::CMS_USER: begin
        done_d = 1'b1;
      end
      default: state_d = cms_pkg::CMS_POR;
    endcase
    if (rq_fall && state_q != cms_pkg::CMS_POR) begin
      state_d = cms_pkg::CMS_WAIT_REQ;
      done_d  = 1'b0;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q   <= cms_pkg::CMS_POR;
      cnt_q     <= '0;
      dsel_q    <= 1'b0;
      pud_q     <= 1'b0;
      sch_q     <= 2'h0;
      cmp_q     <= 1'b0;
      bit_q     <= 3'h0;
      sh_q      <= '0;
      byte_q    <= '0;
      bv_q      <= 1'b0;
      done_q    <= 1'b0;
      rle_esc_q <= 1'b0;
      rle_rep_q <= '0;
      prev_q    <= '0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      dsel_q    <= dsel_d;
      pud_q     <= pud_d;
      sch_q     <= sch_d;
      cmp_q     <= cmp_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      byte_q    <= byte_d;
      bv_q      <= bv_d;
      done_q    <= done_d;
      rle_esc_q <= rle_esc_d;
      rle_rep_q <= rle_rep_d;
      prev_q    <= prev_d;
    end
  end

  always_comb begin
    user_mode      = (state_q == cms_pkg::CMS_USER);
    command_mode   = !user_mode;
    io_oe_n        = !user_mode;
    weak_pullup_en = command_mode && !pud_q;
    user_reg_clear = (state_q == cms_pkg::CMS_INIT);
    cfg_byte_valid = bv_q;
    cfg_byte       = byte_q;
    config_done    = done_q;
  end
endmodule
`default_nettype wire

/* tb/cms_seq_monitor.sv */
// mode, pin and init-length assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module cms_seq_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reconfig_request_n,
  input wire logic command_mode,
  input wire logic user_mode,
  input wire logic io_oe_n,
  input wire logic weak_pullup_en,
  input wire logic user_reg_clear,
  input wire logic cfg_byte_valid,
  input wire logic config_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [4:0] init_q;
  logic [4:0] init_d;
  always_comb init_d = user_reg_clear ? init_q + 5'h1 : 5'h0;
  always_ff @(posedge clock) init_q <= sys_rst ? 5'h0 : init_d;
  a_mode_excl: assert property (command_mode != user_mode)
    else $error("command and user mode not exclusive");
  a_io_hiz: assert property (command_mode |-> io_oe_n)
    else $error("user io driven in command mode");
  a_user_io_on: assert property (user_mode |-> !io_oe_n && config_done)
    else $error("user mode without io enabled and done");
  a_user_pull_off: assert property (user_mode |-> !weak_pullup_en)
    else $error("weak pull-ups on in user mode");
  a_init_len: assert property ($fell(user_reg_clear) |-> init_q == 5'h10)
    else $error("init phase length wrong");
  a_user_entry: assert property ($rose(user_mode) |-> $past(user_reg_clear))
    else $error("user mode entered without init");
  a_reconf_back: assert property ($fell(reconfig_request_n) && user_mode |-> ##[1:8] !user_mode)
    else $error("request did not force command mode");
  a_load_only: assert property (cfg_byte_valid |-> command_mode && !user_reg_clear)
    else $error("byte delivered outside loading");
  cover property ($rose(user_mode));
  cover property ($fell(user_reg_clear));
  cover property (cfg_byte_valid);
endmodule
bind cms_sequencer cms_seq_monitor u_mon (
  .clock(clock), .sys_rst(sys_rst), .reconfig_request_n(reconfig_request_n),
  .command_mode(command_mode), .user_mode(user_mode), .io_oe_n(io_oe_n),
  .weak_pullup_en(weak_pullup_en), .user_reg_clear(user_reg_clear),
  .cfg_byte_valid(cfg_byte_valid), .config_done(config_done));
`default_nettype wire

/* tb/cms_cfg_source.sv */
// configuration source model driving the data pins
`timescale 1ns/1ps
`default_nettype none
module cms_cfg_source (
  input  wire logic       clock,
  output logic            cfg_clk,
  output logic            cfg_wr_n,
  output logic [7:0]      cfg_data
);
  initial begin
    cfg_clk = 1'b0;
    cfg_wr_n = 1'b1;
    cfg_data = 8'h00;
  end
  // levels held 3 cycles each, data inverted once released, one idle cycle after
  task automatic strobe(input logic [1:0] sch, input logic [7:0] d);
    cfg_data = d;
    if (sch == 2'h3) cfg_wr_n = 1'b0;
    repeat (3) @(negedge clock);
    if (sch == 2'h3) cfg_wr_n = 1'b1; else cfg_clk = 1'b1;
    repeat (3) @(negedge clock);
    cfg_clk = 1'b0;
    cfg_data = ~d;
    @(negedge clock);
  endtask
  task automatic send(input logic [1:0] sch, input logic [7:0] b);
    if (sch == 2'h1 || sch == 2'h2) begin
      for (int i = 0; i < 8; i++) strobe(sch, {7'h00, b[i]});
    end else strobe(sch, b);
  endtask
endmodule
`default_nettype wire

/* tb/config_mode_sequencer_test.sv */
// self-checking bench for the configuration mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module config_mode_sequencer_test;
  logic       clock = 1'b0, sys_rst = 1'b1, sel = 1'b0, pud = 1'b1;
  logic       req_n = 1'b1, comp = 1'b0, last = 1'b1;
  logic [1:0] sch = 2'h0;
  logic       cfg_clk, cfg_wr_n, cmd, usr, oe_n, wpu, urc, bv, done;
  logic [7:0] cfg_data, cfg_byte;
  logic [7:0] got[$];
  int         err_total = 0, num_checks = 0;
  always #2.5 clock = ~clock;
  always @(negedge clock) if (bv === 1'b1) got.push_back(cfg_byte);
  cms_sequencer #(.POR_LONG_CYC(40), .POR_SHORT_CYC(20)) DUT (
    .clock(clock), .sys_rst(sys_rst), .power_on_delay_select(sel),
    .preconfig_pullup_disable(pud), .reconfig_request_n(req_n), .load_scheme(sch),
    .compressed(comp), .cfg_clk(cfg_clk), .cfg_wr_n(cfg_wr_n), .cfg_data(cfg_data),
    .cfg_last(last), .command_mode(cmd), .user_mode(usr), .io_oe_n(oe_n),
    .weak_pullup_en(wpu), .user_reg_clear(urc), .cfg_byte_valid(bv),
    .cfg_byte(cfg_byte), .config_done(done));
  cms_cfg_source src (.clock(clock), .cfg_clk(cfg_clk), .cfg_wr_n(cfg_wr_n), .cfg_data(cfg_data));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_user(output int n);
    n = 0;
    while (usr !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
  endtask
  // power-up from reset: delay window per select, pins in command mode
  task automatic t_por(input logic s, input logic p, input int lo);
    int n;
    sel = s;
    pud = p;
    sys_rst = 1'b1;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    `CHK("pullup", ~p, wpu)
    `CHK("io_oe_n", 1'b1, oe_n)
    wait_user(n);
    `CHK("por_min", 1'b1, n >= lo)
    `CHK("por_max", 1'b1, n <= lo + 10)
    $display("power-up test done sel=%0b cycles=%0d", s, n);
  endtask
  // forced reload in a given scheme, with a stray byte sent in user mode
  task automatic t_reconf(input logic [1:0] s, input logic c, input logic p);
    int n;
    logic [7:0] exp [4];
    if (c) exp = '{8'hA5, 8'h3C, 8'h3C, 8'h3C};
    else exp = '{8'hA5, 8'h3C, 8'h00, 8'h02};
    got.delete();
    sch = s;
    comp = c;
    last = 1'b0;
    pud = p;
    sel = ~sel;
    src.send(s, 8'hFF);
    req_n = 1'b0;
    repeat (6) @(negedge clock);
    `CHK("command_mode", 1'b1, cmd)
    req_n = 1'b1;
    repeat (6) @(negedge clock);
    `CHK("pullup", ~p, wpu)
    src.send(s, 8'hA5);
    src.send(s, 8'h3C);
    src.send(s, 8'h00);
    src.send(s, 8'h02);
    repeat (3) @(negedge clock);
    last = 1'b1;
    wait_user(n);
    `CHK("user_mode", 1'b1, usr)
    `CHK("io_oe_n_user", 1'b0, oe_n)
    `CHK("config_done", 1'b1, done)
    `CHK("byte_count", 4, got.size())
    for (int i = 0; i < 4; i++) `CHK("cfg_byte", exp[i], got[i])
    $display("reload test done scheme=%0d compressed=%0b", s, c);
  endtask
  initial begin
    t_por(1'b0, 1'b1, 56);
    t_por(1'b1, 1'b0, 36);
    t_reconf(2'h0, 1'b0, 1'b1);
    t_reconf(2'h1, 1'b1, 1'b0);
    t_reconf(2'h2, 1'b0, 1'b1);
    t_reconf(2'h3, 1'b1, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
